// *** tps_pkg.sv ***
// Shared constants, opcodes and state layout of the trippoint sequencer
package tps_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int TPS_NAX  = 8;      // Number of axes
    localparam int TPS_NSEQ = 2;      // Number of coordinated sequences
    localparam int TPS_NIN  = 48;     // Digital inputs incl. extended
    localparam int TPS_PW   = 32;     // Position and count width

    ////////////////////////////////////////////////////////////////////////
    // Values
    localparam logic [7:0]  TPS_STOP_SETTLE = 8'h63;   // Stop code 99
    localparam logic [31:0] TPS_IN_FIRST    = 32'h1;   // Lowest input
    localparam logic [31:0] TPS_IN_LAST     = 32'h30;  // Highest input 48
    localparam logic [31:0] TPS_ONE         = 32'h1;   // Counter step
    localparam logic [31:0] TPS_RST_W       = 32'h0;   // Word reset value
    localparam logic [7:0]  TPS_RST_B       = 8'h0;    // Byte reset value

    ////////////////////////////////////////////////////////////////////////
    // Wait instructions
    typedef enum logic [3:0] {
        TPS_OP_MOTION_DONE,   // wait_motion_done
        TPS_OP_REL_DIST,      // wait_rel_distance
        TPS_OP_INCR_DIST,     // wait_incr_distance
        TPS_OP_ABS_POS,       // wait_abs_position
        TPS_OP_FWD_CROSS,     // wait_fwd_crossing
        TPS_OP_REV_CROSS,     // wait_rev_crossing
        TPS_OP_IN_POS,        // wait_in_position
        TPS_OP_INPUT,         // hold_input_level
        TPS_OP_SLEW,          // hold_slew_speed
        TPS_OP_REF_TIME,      // hold_ref_time
        TPS_OP_PATH,          // hold_path_distance
        TPS_OP_ELAPSED        // hold_elapsed_time
    } tps_op_t;

    // Sequencer wait state
    typedef enum logic {
        TPS_IDLE,
        TPS_WAIT
    } tps_st_t;

    // Whole state of the block
    typedef struct packed {
        tps_st_t              st;        // Idle or waiting
        tps_op_t              op;        // Pending wait kind
        logic [2:0]           axis;      // Single axis index
        logic [TPS_NAX-1:0]   axes;      // Axis mask
        logic [TPS_NSEQ-1:0]  seqs;      // Sequence mask
        logic [5:0]           inIdx;     // Input index, zero based
        logic signed [31:0]   target;    // Trip point
        logic                 dirUp;     // Upward compare / level high
        logic                 useAux;    // Watch auxiliary input
        logic                 unitSmp;   // Samples instead of ms
        logic [31:0]          cnt;       // Delay or settle counter
        logic signed [31:0]   refPos;    // Incremental reference
        logic [2:0]           refAxis;   // Axis of reference
        logic                 refValid;  // Reference present
        logic [31:0]          refMs;     // Time reference, ms
        logic [31:0]          refSmp;    // Time reference, samples
        logic [31:0]          msNow;     // Free ms counter
        logic [31:0]          smpNow;    // Free sample counter
        logic signed [31:0]   pathRef;   // Path distance reference
        logic [TPS_NIN-1:0]   dinMeta;   // Input sync stage 1
        logic [TPS_NIN-1:0]   dinSync;   // Input sync stage 2
        logic                 trip;      // Release pulse
        logic                 err;       // Command error pulse
        logic                 tout;      // Settle timeout pulse
        logic [7:0]           stopCode;  // Axis stop code
        logic [2:0]           stopAxis;  // Axis of stop code
        logic                 rmErr;     // relative_move refused
        logic                 rmOk;      // relative_move accepted
    } tps_state_t;

endpackage : tps_pkg

// *** tps_trippoint_sequencer.sv ***
// Wait-condition unit that stalls the program sequencer until a trip
//
// What this block does
// (R01) Stall sequencer until decoded wait condition trips
// (R02) Motion done on listed axes; none means all
// (R03) Commanded position reaches relative distance from start
// (R04) Distance accumulates since previous incremental reference
// (R05) Single axis reaches given absolute position
// (R06) Forward crossing trips, immediately if already beyond
// (R07) Reverse crossing trips, immediately if already past
// (R08) In position, or timeout sets code 99, branch
// (R09) Signed input number waits for high or low
// (R10) Listed axes or sequences reach slew speed
// (R11) Reference time load, wait, or wait then advance
// (R12) Distance travelled along coordinated path
// (R13) Delay in milliseconds or servo samples
// (R14) Conditions checked once per servo sample
// (R15) Refuse relative_move while axis still moving
// (R16) Release in first sample condition holds
// (R17) Several axes on single-axis wait is error
`timescale 1ns/1ps
`default_nettype none

module tps_trippoint_sequencer
    import tps_pkg::*;
(
    input  wire logic                     sys_clk,      // Clock 125 MHz
    input  wire logic                     arst_n,       // Async reset
    input  wire logic                     sampleTick,   // Servo sample
    input  wire logic                     msTick,       // Millisecond
    input  wire logic                     instValid,    // Wait decoded
    input  wire tps_op_t                  instOp,       // Wait kind
    input  wire logic [TPS_NAX-1:0]       instAxes,     // Axis selector
    input  wire logic [TPS_NSEQ-1:0]      instSeqs,     // Sequence sel
    input  wire logic signed [31:0]       instArg,      // Argument n
    input  wire logic                     instUnit,     // m: 1=samples
    input  wire logic                     instAux,      // Aux encoder
    output logic                          instReady,    // Can take wait
    output logic                          holdSeq,      // Stall sequencer
    output logic                          tripDone,     // Wait released
    output logic                          cmdErr,       // Command error
    output logic                          settleTout,   // Timeout event
    output logic                          branchHandler,// Go to handler
    output logic [7:0]                    stopCode,     // Stop code
    output logic [2:0]                    stopAxis,     // Stop code axis
    input  wire logic [TPS_NAX-1:0][31:0] cmdPos,       // Commanded pos
    input  wire logic [TPS_NAX-1:0][31:0] encPos,       // Encoder pos
    input  wire logic [TPS_NAX-1:0][31:0] auxPos,       // Aux encoder
    input  wire logic [TPS_NAX-1:0][31:0] moveStart,    // Move start pos
    input  wire logic [TPS_NAX-1:0]       axisDone,     // Profile done
    input  wire logic [TPS_NAX-1:0]       axisMoving,   // Axis moving
    input  wire logic [TPS_NAX-1:0]       atSlew,       // At slew speed
    input  wire logic [TPS_NSEQ-1:0]      seqDone,      // Sequence done
    input  wire logic [TPS_NSEQ-1:0]      seqAtSlew,    // Seq at speed
    input  wire logic signed [31:0]       pathDist,     // Path travelled
    input  wire logic                     pathRestart,  // New sequence
    input  wire logic [31:0]              settleLimit,  // Samples, 0=off
    input  wire logic [TPS_NIN-1:0]       din,          // Input pins
    input  wire logic                     rmValid,      // relative_move
    input  wire logic [TPS_NAX-1:0]       rmAxes,       // Its axes
    output logic                          rmErr,        // Refused
    output logic                          rmOk          // Accepted
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Index of the lowest set axis bit
    function automatic logic [2:0] axisIndex(input logic [7:0] m);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = TPS_NAX - 1; i >= 0; i--) begin
            if (m[i]) begin
                idx = i[2:0];
            end
        end
        return idx;
    endfunction : axisIndex

    tps_state_t         r;          // Registered state
    tps_state_t         n;          // Next state
    logic [2:0]         newAx;      // Selected axis of request
    logic               singleOp;   // Request wants one axis
    logic               badReq;     // Request is a command error
    logic signed [31:0] absArg;     // Magnitude of argument
    logic signed [31:0] incBase;    // Base for incremental distance
    logic signed [31:0] curCmd;     // Commanded pos of pending axis
    logic signed [31:0] curObs;     // Watched pos for crossings
    logic signed [31:0] curEnc;     // Encoder pos of pending axis
    logic               reach;      // Commanded pos at trip point
    logic               encReach;   // Encoder at commanded pos
    logic [31:0]        elapsed;    // Time since reference
    logic               cond;       // Pending condition holds
    logic               unitTick;   // Tick of chosen time unit

    ////////////////////////////////////////////////////////////////////////
    // Request decode
    always_comb begin
        newAx    = axisIndex(instAxes);
        singleOp = instOp inside {TPS_OP_REL_DIST, TPS_OP_INCR_DIST,
                                  TPS_OP_ABS_POS, TPS_OP_FWD_CROSS,
                                  TPS_OP_REV_CROSS, TPS_OP_IN_POS};
        absArg   = instArg[31] ? -instArg : instArg;
        // Several or no axes on a single-axis wait
        badReq   = singleOp && !$onehot(instAxes);  // see (R17)
        if (instOp == TPS_OP_INPUT) begin
            // Input number out of range or zero
            badReq = (absArg < $signed(TPS_IN_FIRST)) ||
                     (absArg > $signed(TPS_IN_LAST));  // see (R09)
        end
        if (instOp == TPS_OP_SLEW) begin
            badReq = (instAxes == '0) && (instSeqs == '0);
        end
        // Continue from previous reference on same axis
        incBase = (r.refValid && r.refAxis == newAx) ? r.refPos
                : $signed(moveStart[newAx]);  // see (R04)
    end

    ////////////////////////////////////////////////////////////////////////
    // Condition evaluation of the pending wait
    always_comb begin
        curCmd   = $signed(cmdPos[r.axis]);
        curEnc   = $signed(encPos[r.axis]);
        curObs   = r.useAux ? $signed(auxPos[r.axis]) : curCmd;
        reach    = r.dirUp ? (curCmd >= r.target) : (curCmd <= r.target);
        encReach = r.dirUp ? (curEnc >= $signed(cmdPos[r.axis]))
                           : (curEnc <= $signed(cmdPos[r.axis]));
        elapsed  = r.unitSmp ? (r.smpNow - r.refSmp) : (r.msNow - r.refMs);
        unitTick = r.unitSmp ? sampleTick : msTick;
        case (r.op)
            TPS_OP_MOTION_DONE: begin
                cond = &(axisDone | ~r.axes) &&
                       &(seqDone | ~r.seqs);  // see (R02)
            end
            TPS_OP_REL_DIST,
            TPS_OP_INCR_DIST,
            TPS_OP_ABS_POS: begin
                cond = reach;  // see (R03) (R04) (R05)
            end
            TPS_OP_FWD_CROSS: begin
                cond = curObs >= r.target;  // see (R06)
            end
            TPS_OP_REV_CROSS: begin
                cond = curObs <= r.target;  // see (R07)
            end
            TPS_OP_IN_POS: begin
                cond = axisDone[r.axis] && encReach;  // see (R08)
            end
            TPS_OP_INPUT: begin
                cond = r.dinSync[r.inIdx] == r.dirUp;  // see (R09)
            end
            TPS_OP_SLEW: begin
                cond = &(atSlew | ~r.axes) &&
                       &(seqAtSlew | ~r.seqs);  // see (R10)
            end
            TPS_OP_REF_TIME: begin
                cond = elapsed >= r.target;  // see (R11)
            end
            TPS_OP_PATH: begin
                cond = pathDist >= r.target;  // see (R12)
            end
            TPS_OP_ELAPSED: begin
                cond = r.cnt == TPS_RST_W;  // see (R13)
            end
            default: begin
                cond = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        n       = r;
        n.trip  = 1'b0;
        n.err   = 1'b0;
        n.tout  = 1'b0;
        // Input pins pass two flops before use
        n.dinMeta = din;
        n.dinSync = r.dinMeta;
        // Free-running time bases
        if (msTick) begin
            n.msNow = r.msNow + TPS_ONE;
        end
        if (sampleTick) begin
            n.smpNow = r.smpNow + TPS_ONE;
        end
        if (pathRestart) begin
            n.pathRef = TPS_RST_W;
        end
        // Move request while axis still busy is refused
        n.rmErr = rmValid && |(rmAxes & axisMoving);   // see (R15)
        n.rmOk  = rmValid && !(|(rmAxes & axisMoving));
        case (r.st)
            TPS_IDLE: begin
                if (instValid && badReq) begin
                    n.err = 1'b1;  // see (R17)
                end else if (instValid) begin
                    n.st      = TPS_WAIT;  // see (R01)
                    n.op      = instOp;
                    n.axis    = newAx;
                    n.axes    = instAxes;
                    n.seqs    = instSeqs;
                    n.useAux  = instAux;
                    n.unitSmp = instUnit;
                    n.target  = instArg;
                    n.dirUp   = !instArg[31];
                    n.inIdx   = 6'(absArg - $signed(TPS_IN_FIRST));
                    n.cnt     = TPS_RST_W;
                    case (instOp)
                        TPS_OP_MOTION_DONE: begin
                            // Empty selector means everything
                            if (instAxes == '0 && instSeqs == '0) begin
                                n.axes = '1;  // see (R02)
                                n.seqs = '1;
                            end
                        end
                        TPS_OP_REL_DIST: begin
                            n.target = $signed(moveStart[newAx]) + instArg;
                        end
                        TPS_OP_INCR_DIST: begin
                            n.target = incBase + instArg;  // see (R04)
                        end
                        TPS_OP_ABS_POS: begin
                            n.dirUp = instArg >= $signed(cmdPos[newAx]);
                        end
                        TPS_OP_REF_TIME: begin
                            n.target = absArg;
                            if (instArg == TPS_RST_W) begin
                                // Load reference, no wait
                                n.st     = TPS_IDLE;  // see (R11)
                                n.refMs  = r.msNow;
                                n.refSmp = r.smpNow;
                                n.trip   = 1'b1;
                            end
                        end
                        TPS_OP_PATH: begin
                            n.target = r.pathRef + instArg;  // see (R12)
                        end
                        TPS_OP_ELAPSED: begin
                            n.cnt = instArg[31] ? TPS_RST_W : instArg;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            TPS_WAIT: begin
                if (r.op == TPS_OP_ELAPSED && unitTick &&
                    r.cnt != TPS_RST_W) begin
                    n.cnt = r.cnt - TPS_ONE;  // see (R13)
                end
                if (r.op == TPS_OP_IN_POS && sampleTick &&
                    axisDone[r.axis]) begin
                    n.cnt = r.cnt + TPS_ONE;
                end
                // Conditions only looked at on a servo sample
                if (sampleTick && cond) begin  // see (R14) (R16)
                    n.st   = TPS_IDLE;
                    n.trip = 1'b1;
                    if (r.op inside {TPS_OP_REL_DIST, TPS_OP_INCR_DIST}) begin
                        n.refPos   = r.target;  // see (R04)
                        n.refAxis  = r.axis;
                        n.refValid = 1'b1;
                    end
                    if (r.op == TPS_OP_REF_TIME && !r.dirUp) begin
                        // Negative form moves reference on
                        if (r.unitSmp) begin
                            n.refSmp = r.refSmp + r.target;  // see (R11)
                        end else begin
                            n.refMs = r.refMs + r.target;
                        end
                    end
                    if (r.op == TPS_OP_PATH) begin
                        n.pathRef = r.target;
                    end
                end else if (sampleTick && r.op == TPS_OP_IN_POS &&
                             axisDone[r.axis] && settleLimit != TPS_RST_W &&
                             r.cnt + TPS_ONE >= settleLimit) begin
                    // Settle timeout clears the wait
                    n.st       = TPS_IDLE;  // see (R08)
                    n.tout     = 1'b1;
                    n.stopCode = TPS_STOP_SETTLE;
                    n.stopAxis = r.axis;
                end
            end
            default: begin
                n.st = TPS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            r          <= '0;
            r.st       <= TPS_IDLE;
            r.stopCode <= TPS_RST_B;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign instReady     = r.st == TPS_IDLE;
    assign holdSeq       = r.st == TPS_WAIT;  // see (R01)
    assign tripDone      = r.trip;
    assign cmdErr        = r.err;
    assign settleTout    = r.tout;
    assign branchHandler = r.tout;  // see (R08)
    assign stopCode      = r.stopCode;
    assign stopAxis      = r.stopAxis;
    assign rmErr         = r.rmErr;
    assign rmOk          = r.rmOk;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence sWaitTick;
        r.st == TPS_WAIT && sampleTick;
    endsequence

    sequence sBadSingle;
        r.st == TPS_IDLE && instValid && singleOp && !$onehot(instAxes);
    endsequence

    a_hold_no_tick: assert property (  // see (R01)
        @(posedge sys_clk) disable iff (!arst_n)
        r.st == TPS_WAIT && !sampleTick |=> holdSeq)
        else $error("wait left without a sample");
    a_trip_on_sample: assert property (  // see (R14)
        @(posedge sys_clk) disable iff (!arst_n)
        tripDone && !$past(instValid) |-> $past(sampleTick))
        else $error("release outside a servo sample");
    a_settle_code: assert property (  // see (R08)
        @(posedge sys_clk) disable iff (!arst_n)
        settleTout |-> stopCode == TPS_STOP_SETTLE && branchHandler &&
        !holdSeq)
        else $error("timeout without stop code 99");
    a_multi_axis: assert property (  // see (R17)
        @(posedge sys_clk) disable iff (!arst_n)
        sBadSingle |=> cmdErr && !holdSeq)
        else $error("multi-axis single wait not refused");
    a_move_refuse: assert property (  // see (R15)
        @(posedge sys_clk) disable iff (!arst_n)
        rmValid && |(rmAxes & axisMoving) |=> rmErr && !rmOk)
        else $error("relative_move accepted while moving");
    a_fwd_release: assert property (  // see (R06)
        @(posedge sys_clk) disable iff (!arst_n)
        sWaitTick ##0 (r.op == TPS_OP_FWD_CROSS && curObs >= r.target)
        |=> tripDone && !holdSeq)
        else $error("forward crossing not released");
    a_rev_release: assert property (  // see (R07)
        @(posedge sys_clk) disable iff (!arst_n)
        sWaitTick ##0 (r.op == TPS_OP_REV_CROSS && curObs <= r.target)
        |=> tripDone)
        else $error("reverse crossing not released");
    a_motion_done: assert property (  // see (R02)
        @(posedge sys_clk) disable iff (!arst_n)
        sWaitTick ##0 (r.op == TPS_OP_MOTION_DONE &&
        &(axisDone | ~r.axes) && &(seqDone | ~r.seqs)) |=> tripDone)
        else $error("motion done not released");
    a_input_level: assert property (  // see (R09)
        @(posedge sys_clk) disable iff (!arst_n)
        sWaitTick ##0 (r.op == TPS_OP_INPUT &&
        r.dinSync[r.inIdx] != r.dirUp) |=> holdSeq && !tripDone)
        else $error("input wait released at wrong level");
    a_first_sample: assert property (  // see (R16)
        @(posedge sys_clk) disable iff (!arst_n)
        sWaitTick ##0 cond |=> !holdSeq)
        else $error("wait held past first true sample");

endmodule : tps_trippoint_sequencer

`default_nettype wire

// *** tps_axis_model.sv ***
// Behavioural axes, encoders and timers beside the trippoint sequencer
`timescale 1ns/1ps
`default_nettype none
module tps_axis_model
    import tps_pkg::*;
(
    input  wire logic                sys_clk,    // Clock
    input  wire logic                arst_n,     // Async reset
    input  wire logic                go,         // Start axis 0 move
    output logic                     sampleTick, // Servo sample
    output logic                     msTick,     // Millisecond
    output logic [TPS_NAX-1:0][31:0] cmdPos,     // Commanded positions
    output logic [TPS_NAX-1:0][31:0] encPos,     // Encoder, axis 1 held at 0
    output logic [TPS_NAX-1:0]       axisDone,   // Profile done
    output logic [TPS_NAX-1:0]       axisMoving  // Axis 0 in motion
);
    logic [3:0] div; // Tick divider
    ////////////////////////////////////////////////////////////////////////
    // Sample every 4 cycles, millisecond every 16
    assign sampleTick = (div[1:0] == 2'h3);
    assign msTick     = (div == 4'hf);
    assign axisDone   = ~axisMoving;
    // Axis 1 encoder never reaches its command
    always_comb begin
        encPos    = cmdPos;
        encPos[1] = 32'h0;
    end
    // Axis 0 moves 10 counts a sample, stops at 40
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            div        <= 4'h0;
            cmdPos     <= '0;
            cmdPos[1]  <= 32'h32;
            axisMoving <= '0;
        end else begin
            div <= div + 4'h1;
            if (go) begin
                axisMoving[0] <= 1'b1;
            end else if (sampleTick && axisMoving[0]) begin
                cmdPos[0]     <= cmdPos[0] + 32'ha;
                axisMoving[0] <= (cmdPos[0] != 32'h1e);
            end
        end
    end
endmodule : tps_axis_model
`default_nettype wire

// *** trippoint_sequencer_tb.sv ***
// Self-checking bench of the trippoint sequencer
`timescale 1ns/1ps
`default_nettype none
module trippoint_sequencer_tb;
    import tps_pkg::*;
    typedef struct {tps_op_t op; logic [7:0] ax; logic [31:0] arg;
        logic un; logic [2:0] res; int mn;} tps_row_t;
    logic sys_clk = 0, arst_n = 0, instValid = 0, instUnit = 0, go = 0;
    logic rmValid = 0, sampleTick, msTick, instReady, holdSeq, tripDone;
    logic cmdErr, settleTout, branchHandler, rmErr, rmOk, instAux = 0;
    tps_op_t op = TPS_OP_MOTION_DONE;
    logic [7:0] instAxes = 0, rmAxes = 0, axisDone, axisMoving, stopCode;
    logic [31:0] instArg = 0, settleLimit = 32'h3, pathDist = 0;
    logic [47:0] din = 0;
    logic [2:0] stopAxis, res;
    logic [TPS_NAX-1:0][31:0] cmdPos, encPos;
    int n_errors = 0, cmp_count = 0, k;
    tps_row_t rows[17] = '{
      '{TPS_OP_MOTION_DONE, 8'h0, 32'h0, 1'b0, 3'h1, 0},
      '{TPS_OP_REL_DIST, 8'h1, 32'h0, 1'b0, 3'h1, 0},
      '{TPS_OP_INCR_DIST, 8'h1, 32'h0, 1'b0, 3'h1, 0},
      '{TPS_OP_ABS_POS, 8'h1, 32'h0, 1'b0, 3'h1, 0},
      '{TPS_OP_FWD_CROSS, 8'h1, 32'hfffffffb, 1'b0, 3'h1, 0},
      '{TPS_OP_REV_CROSS, 8'h1, 32'h5, 1'b0, 3'h1, 0},
      '{TPS_OP_FWD_CROSS, 8'h3, 32'h0, 1'b0, 3'h2, 0},
      '{TPS_OP_INPUT, 8'h0, 32'hffffffff, 1'b0, 3'h1, 0},
      '{TPS_OP_INPUT, 8'h0, 32'h31, 1'b0, 3'h2, 0},
      '{TPS_OP_SLEW, 8'h0, 32'h0, 1'b0, 3'h2, 0},
      '{TPS_OP_PATH, 8'h0, 32'h0, 1'b0, 3'h1, 0},
      '{TPS_OP_ELAPSED, 8'h0, 32'h3, 1'b1, 3'h1, 8},
      '{TPS_OP_ELAPSED, 8'h0, 32'h2, 1'b0, 3'h1, 12},
      '{TPS_OP_REF_TIME, 8'h0, 32'h0, 1'b0, 3'h1, 0},
      '{TPS_OP_REF_TIME, 8'h0, 32'hfffffffd, 1'b1, 3'h1, 8},
      '{TPS_OP_REF_TIME, 8'h0, 32'h3, 1'b1, 3'h1, 8},
      '{TPS_OP_IN_POS, 8'h2, 32'h0, 1'b0, 3'h4, 8}};
    always #4 sys_clk = ~sys_clk;
    tps_axis_model model (.sys_clk, .arst_n, .go, .sampleTick, .msTick,
        .cmdPos, .encPos, .axisDone, .axisMoving);
    tps_trippoint_sequencer dut (.sys_clk, .arst_n, .sampleTick, .msTick,
        .instValid, .instOp(op), .instAxes, .instSeqs(2'h0), .instArg,
        .instUnit, .instAux, .instReady, .holdSeq, .tripDone, .cmdErr,
        .settleTout, .branchHandler, .stopCode, .stopAxis, .cmdPos, .encPos,
        .auxPos(encPos), .moveStart('0), .axisDone, .axisMoving,
        .atSlew(axisMoving), .seqDone(2'h3), .seqAtSlew(2'h0),
        .pathDist, .pathRestart(1'b0), .settleLimit, .din, .rmValid,
        .rmAxes, .rmErr, .rmOk);
    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    // Verdict and end of run
    task results();
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    // Present one wait, then count cycles up to its outcome
    task issue(input tps_row_t r);
        @(negedge sys_clk);
        op = r.op;
        {instAxes, instArg, instUnit, instValid} = {r.ax, r.arg, r.un, 1'b1};
        @(posedge sys_clk);
        #1 res = {settleTout, cmdErr, tripDone};
        @(negedge sys_clk);
        instValid = 0;
        for (k = 0; k < 300 && res == 0; k++) begin
            @(posedge sys_clk);
            #1 res = {settleTout, cmdErr, tripDone};
        end
        check(res, r.res);
        check(k >= r.mn, 1);
    endtask : issue
    // Relative move request, answer one cycle on
    task relMove(input logic [1:0] exp);
        @(negedge sys_clk);
        {rmValid, rmAxes} = 9'h101;
        @(posedge sys_clk);
        #1 check({rmErr, rmOk}, exp);
        @(negedge sys_clk);
        rmValid = 0;
    endtask : relMove
    initial begin
        #200000 n_errors++;
        results();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        #1 check({instReady, holdSeq, stopCode}, 10'h200);
        @(negedge sys_clk) arst_n = 1;
        foreach (rows[i]) issue(rows[i]);
        check({branchHandler, stopCode, stopAxis},
              {1'b1, TPS_STOP_SETTLE, 3'h1});
        // Aux encoder of axis 1 sits at 0 while its command is at 50
        @(negedge sys_clk) {instAux, pathDist} = {1'b1, 32'h5};
        issue('{TPS_OP_REV_CROSS, 8'h2, 32'h14, 1'b0, 3'h1, 0});
        issue('{TPS_OP_PATH, 8'h0, 32'h5, 1'b0, 3'h1, 0});
        @(negedge sys_clk) go = 1;
        @(negedge sys_clk) go = 0;
        relMove(2'h2);
        issue('{TPS_OP_MOTION_DONE, 8'h1, 32'h0, 1'b0, 3'h1, 12});
        relMove(2'h1);
        results();
    end
endmodule : trippoint_sequencer_tb
`default_nettype wire
